// ===== common/dma_pkg.sv
// constants, field layout and types of the bus-to-bus dma unit
// assumes a plain register port with 16-bit byte addresses, 64-bit data
package dma_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register port widths and offsets
    localparam int ADDR_W = 16;
    localparam int DATA_W = 64;
    localparam logic [15:0] OFS_PCI_ADDR = 16'hD210;
    localparam logic [15:0] OFS_COUNT = 16'hD218;
    localparam logic [15:0] OFS_CONFIG = 16'hD220;
    localparam logic [15:0] OFS_CONTROL = 16'hD228;
    localparam logic [15:0] OFS_IRQ_STATUS = 16'hD230;
    localparam logic [15:0] OFS_IRQ_CLEAR = 16'hD238;
    localparam logic [15:0] OFS_IRQ_ENABLE = 16'hD240;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PA_LSB = 2;
    localparam int PA_MSB = 39;
    localparam int PA_W = PA_MSB - PA_LSB + 1;
    localparam int CNT_LSB = 2;
    localparam int CNT_MSB = 23;
    localparam int CNT_W = CNT_MSB - CNT_LSB + 1;
    localparam int CFG_FIFO_CLR = 21;
    localparam int CFG_BYTE_ORDER = 20;
    localparam int CFG_GAP_MSB = 13;
    localparam int CFG_GAP_LSB = 11;
    localparam int CFG_ERR_IE = 10;
    localparam int CFG_CHAIN_IE = 9;
    localparam int CTL_DONE_IE = 8;
    localparam int CTL_CHAIN_EN = 7;
    localparam int CTL_RUN = 6;
    localparam int CTL_DIR = 0;
    // interrupt status, clear and enable share this layout
    localparam int IRQ_ERR = 0;
    localparam int IRQ_CHAIN = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic [2:0] GAP_NONE = 3'h0;
    localparam logic [10:0] GAP_UNIT = 11'h008;
    localparam logic [10:0] GAP_SAT = 11'h7FF;
    localparam logic [11:0] SEEN_SAT = 12'hFFF;
    localparam logic [PA_W-1:0] PA_STEP = 38'h1;
    localparam logic [CNT_W-1:0] CNT_STEP = 22'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 22'h0;

    typedef enum logic [1:0] {
        IDLE,
        GAP_WAIT,
        IBUS,
        PCI
    } xfer_state_e;

    // minimum internal-bus clocks between requests: 0, then 16 up to 1024
    function automatic logic [10:0] gap_cycles(input logic [2:0] sel);
        gap_cycles = (sel == GAP_NONE) ? 11'h000 : 11'(GAP_UNIT << sel);
    endfunction : gap_cycles

    function automatic logic reg_hit(input logic [15:0] addr,
                                     input logic [15:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

endpackage : dma_pkg

// ===== rtl/request_gap_timer.sv
// spacing timer between internal-bus requests of the dma unit
// assumes issue is a one-cycle pulse on sys_clk when a request starts
`timescale 1ns/10ps
module request_gap_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic [2:0] gap_select,
    input wire logic issue,
    // status
    output logic gap_ok
);

    logic [10:0] since;
    logic [10:0] next_since;
    logic [10:0] need;

    ////////////////////////////////////////////////////////////////////////
    // clocks since the last request, saturating so the first one is free
    assign need = dma_pkg::gap_cycles(gap_select); // see R12

    always_comb begin
        next_since = since;
        if (issue) begin
            next_since = 11'h001;
        end else if (since != dma_pkg::GAP_SAT) begin
            next_since = since + 11'h001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            since <= dma_pkg::GAP_SAT;
        end else begin
            since <= next_since;
        end
    end

    // code zero lets requests run back to back
    assign gap_ok = (gap_select == dma_pkg::GAP_NONE)
                  || (since >= need); // see R11

endmodule : request_gap_timer

// ===== rtl/bus_to_bus_dma_unit.sv
// register set and word engine of the bus-to-bus dma unit
// assumes a plain register port on sys_clk, an internal-bus agent on
// sys_clk and a pci agent on its own pci_clk, sampled here
//
// Notes on behaviour
// R01: pci address bits 39:2, word aligned
// R02: pci address used for pci write or read
// R03: address and count survive reset
// R04: count bits 23:2, unit is one word
// R05: software programs count multiple of size
// R06: zero count moves no data
// R07: count drops as words move
// R08: fifo clear bit holds fifo pointers cleared
// R09: software clears fifo clear bit itself
// R10: byte order bit tells internal bus endianness
// R11: gap code zero means back to back
// R12: gap codes give 16 to 1024 clocks
// R13: error interrupt enable gates error interrupt
// R14: chain interrupt enable gates chain interrupt
// R15: running bit starts, hardware clears at end
// R16: done interrupt enable gates done interrupt
// R17: sticky status, one combined interrupt line
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module bus_to_bus_dma_unit (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [63:0] reg_rdata,
    // internal bus agent
    output logic ibus_req,
    output logic ibus_write,
    input wire logic ibus_ack,
    input wire logic ibus_error,
    output logic internal_bus_byte_order,
    output logic fifo_pointer_clear,
    // descriptor chain logic
    input wire logic chain_enable,
    input wire logic chain_start,
    // pci agent
    input wire logic pci_clk,
    input wire logic pci_word_done,
    input wire logic pci_error,
    output logic pci_access_valid,
    output logic pci_access_write,
    output logic [39:0] pci_access_addr,
    // interrupt
    output logic irq
);

    // kept through reset, no reset term
    logic [dma_pkg::PA_W-1:0] pci_side_transfer_address;
    logic [dma_pkg::PA_W-1:0] next_pci_side_transfer_address;
    logic [dma_pkg::CNT_W-1:0] transfer_byte_count;
    logic [dma_pkg::CNT_W-1:0] next_transfer_byte_count;
    // configuration and control
    logic next_fifo_pointer_clear;
    logic next_internal_bus_byte_order;
    logic [2:0] request_gap_select;
    logic [2:0] next_request_gap_select;
    logic error_irq_enable;
    logic next_error_irq_enable;
    logic chain_done_irq_enable;
    logic next_chain_done_irq_enable;
    logic transfer_done_irq_enable;
    logic next_transfer_done_irq_enable;
    logic transfer_running;
    logic next_transfer_running;
    logic pci_to_ibus;
    logic next_pci_to_ibus;
    logic [dma_pkg::IRQ_W-1:0] irq_status;
    logic [dma_pkg::IRQ_W-1:0] next_irq_status;
    logic [dma_pkg::IRQ_W-1:0] irq_enable_vec;
    logic [dma_pkg::IRQ_W-1:0] irq_events;
    logic [63:0] next_reg_rdata;
    // engine
    dma_pkg::xfer_state_e state;
    dma_pkg::xfer_state_e next_state;
    logic word_step;
    logic ev_err;
    logic ev_xfer_done;
    logic ev_chain_done;
    logic ibus_issue;
    logic gap_ok;
    // link sampling
    logic link_clk_s1;
    logic link_clk_s2;
    logic link_clk_s3;
    logic done_s1;
    logic done_s2;
    logic err_s1;
    logic err_s2;
    logic link_fall;
    // helper for the spacing check only
    logic [11:0] gap_seen;

    ////////////////////////////////////////////////////////////////////////
    // two flops on pci_word_done and pci_error, three on pci_clk; s1 feeds s2 only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_clk_s1 <= 1'b0;
            link_clk_s2 <= 1'b0;
            link_clk_s3 <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            err_s1 <= 1'b0;
            err_s2 <= 1'b0;
        end else begin
            link_clk_s1 <= pci_clk;
            link_clk_s2 <= link_clk_s1;
            link_clk_s3 <= link_clk_s2;
            done_s1 <= pci_word_done;
            done_s2 <= done_s1;
            err_s1 <= pci_error;
            err_s2 <= err_s1;
        end
    end

    // the agent changes after its rising edge, so sample at the falling one
    assign link_fall = link_clk_s3 && !link_clk_s2;

    ////////////////////////////////////////////////////////////////////////
    // word engine: one word per pass, count checked before each word
    always_comb begin
        next_state = state;
        word_step = 1'b0;
        ev_err = 1'b0;
        ev_xfer_done = 1'b0;
        ev_chain_done = 1'b0;
        case (state)
            dma_pkg::IDLE: begin
                if (transfer_running) begin
                    if (transfer_byte_count == dma_pkg::CNT_ZERO) begin
                        ev_xfer_done = 1'b1; // see R06
                        ev_chain_done = !chain_enable;
                    end else if (pci_to_ibus) begin
                        next_state = dma_pkg::PCI;
                    end else begin
                        next_state = dma_pkg::GAP_WAIT;
                    end
                end
            end
            dma_pkg::GAP_WAIT: begin
                if (gap_ok) begin
                    next_state = dma_pkg::IBUS; // see R11
                end
            end
            dma_pkg::IBUS: begin
                if (ibus_error) begin
                    ev_err = 1'b1;
                    next_state = dma_pkg::IDLE;
                end else if (ibus_ack) begin
                    if (pci_to_ibus) begin
                        word_step = 1'b1;
                        next_state = dma_pkg::IDLE;
                    end else begin
                        next_state = dma_pkg::PCI;
                    end
                end
            end
            dma_pkg::PCI: begin
                if (link_fall && err_s2) begin
                    ev_err = 1'b1;
                    next_state = dma_pkg::IDLE;
                end else if (link_fall && done_s2) begin
                    if (pci_to_ibus) begin
                        next_state = dma_pkg::GAP_WAIT;
                    end else begin
                        word_step = 1'b1;
                        next_state = dma_pkg::IDLE;
                    end
                end
            end
            default: begin
                next_state = dma_pkg::IDLE;
            end
        endcase
    end

    assign ibus_issue = (state == dma_pkg::GAP_WAIT) && gap_ok;

    request_gap_timer gap_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .gap_select(request_gap_select),
        .issue(ibus_issue),
        .gap_ok(gap_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // address and count: software write wins over the hardware step
    always_comb begin
        next_pci_side_transfer_address = pci_side_transfer_address;
        next_transfer_byte_count = transfer_byte_count;
        if (word_step) begin
            next_pci_side_transfer_address = pci_side_transfer_address
                                           + dma_pkg::PA_STEP; // see R01
            next_transfer_byte_count = transfer_byte_count
                                     - dma_pkg::CNT_STEP; // see R07
        end
        if (reg_wr && dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_PCI_ADDR)) begin
            next_pci_side_transfer_address =
                reg_wdata[dma_pkg::PA_MSB:dma_pkg::PA_LSB];
        end
        if (reg_wr && dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_COUNT)) begin
            next_transfer_byte_count =
                reg_wdata[dma_pkg::CNT_MSB:dma_pkg::CNT_LSB]; // see R04
        end
    end

    // no reset on purpose: contents must outlive a reset
    always_ff @(posedge sys_clk) begin
        pci_side_transfer_address <= next_pci_side_transfer_address; // see R03
        transfer_byte_count <= next_transfer_byte_count;
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration, control, sticky status and read data
    assign irq_events = {ev_xfer_done, ev_chain_done, ev_err};

    always_comb begin
        next_fifo_pointer_clear = fifo_pointer_clear;
        next_internal_bus_byte_order = internal_bus_byte_order;
        next_request_gap_select = request_gap_select;
        next_error_irq_enable = error_irq_enable;
        next_chain_done_irq_enable = chain_done_irq_enable;
        next_transfer_done_irq_enable = transfer_done_irq_enable;
        next_transfer_running = transfer_running;
        next_pci_to_ibus = pci_to_ibus;
        next_irq_status = irq_status;
        next_reg_rdata = 64'h0000_0000_0000_0000;
        // hardware clear first so a software set in the same cycle wins
        if (ev_err || ev_xfer_done) begin
            next_transfer_running = 1'b0; // see R15
        end
        if (reg_wr && dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_CONFIG)) begin
            // the clear bit stays until software writes it back
            next_fifo_pointer_clear = reg_wdata[dma_pkg::CFG_FIFO_CLR];
            next_internal_bus_byte_order =
                reg_wdata[dma_pkg::CFG_BYTE_ORDER]; // see R10
            next_request_gap_select =
                reg_wdata[dma_pkg::CFG_GAP_MSB:dma_pkg::CFG_GAP_LSB];
            next_error_irq_enable = reg_wdata[dma_pkg::CFG_ERR_IE];
            next_chain_done_irq_enable = reg_wdata[dma_pkg::CFG_CHAIN_IE];
        end
        if (reg_wr && dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_CONTROL)) begin
            next_transfer_done_irq_enable = reg_wdata[dma_pkg::CTL_DONE_IE];
            next_pci_to_ibus = reg_wdata[dma_pkg::CTL_DIR]; // see R02
            // a start with nothing to move and no chain is dropped
            next_transfer_running = reg_wdata[dma_pkg::CTL_RUN]
                && ((transfer_byte_count != dma_pkg::CNT_ZERO)
                    || chain_enable); // see R15
        end
        if (reg_wr
            && dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_IRQ_ENABLE)) begin
            next_error_irq_enable = reg_wdata[dma_pkg::IRQ_ERR];
            next_chain_done_irq_enable = reg_wdata[dma_pkg::IRQ_CHAIN];
            next_transfer_done_irq_enable = reg_wdata[dma_pkg::IRQ_DONE];
        end
        if (chain_start) begin
            next_transfer_running = 1'b1;
        end
        // write one to clear; a new event in the same cycle stays set
        if (reg_wr && dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_IRQ_CLEAR)) begin
            next_irq_status = irq_status
                            & ~reg_wdata[dma_pkg::IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | irq_events; // see R17
        if (reg_rd) begin
            if (dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_PCI_ADDR)) begin
                next_reg_rdata[dma_pkg::PA_MSB:dma_pkg::PA_LSB] =
                    pci_side_transfer_address;
            end else if (dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_COUNT)) begin
                next_reg_rdata[dma_pkg::CNT_MSB:dma_pkg::CNT_LSB] =
                    transfer_byte_count;
            end else if (dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_CONFIG)) begin
                next_reg_rdata[dma_pkg::CFG_FIFO_CLR] = fifo_pointer_clear;
                next_reg_rdata[dma_pkg::CFG_BYTE_ORDER] =
                    internal_bus_byte_order;
                next_reg_rdata[dma_pkg::CFG_GAP_MSB:dma_pkg::CFG_GAP_LSB] =
                    request_gap_select;
                next_reg_rdata[dma_pkg::CFG_ERR_IE] = error_irq_enable;
                next_reg_rdata[dma_pkg::CFG_CHAIN_IE] = chain_done_irq_enable;
            end else if (dma_pkg::reg_hit(reg_addr, dma_pkg::OFS_CONTROL)) begin
                next_reg_rdata[dma_pkg::CTL_DONE_IE] =
                    transfer_done_irq_enable;
                next_reg_rdata[dma_pkg::CTL_CHAIN_EN] = chain_enable;
                next_reg_rdata[dma_pkg::CTL_RUN] = transfer_running;
                next_reg_rdata[dma_pkg::CTL_DIR] = pci_to_ibus;
            end else if (dma_pkg::reg_hit(reg_addr,
                                          dma_pkg::OFS_IRQ_STATUS)) begin
                next_reg_rdata[dma_pkg::IRQ_W-1:0] = irq_status;
            end else if (dma_pkg::reg_hit(reg_addr,
                                          dma_pkg::OFS_IRQ_ENABLE)) begin
                next_reg_rdata[dma_pkg::IRQ_W-1:0] = irq_enable_vec;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fifo_pointer_clear <= 1'b0;
            internal_bus_byte_order <= 1'b0;
            request_gap_select <= dma_pkg::GAP_NONE;
            error_irq_enable <= 1'b0;
            chain_done_irq_enable <= 1'b0;
            transfer_done_irq_enable <= 1'b0;
            transfer_running <= 1'b0;
            pci_to_ibus <= 1'b0;
            irq_status <= 3'h0;
            reg_rdata <= 64'h0000_0000_0000_0000;
            state <= dma_pkg::IDLE;
        end else begin
            fifo_pointer_clear <= next_fifo_pointer_clear; // see R08
            internal_bus_byte_order <= next_internal_bus_byte_order;
            request_gap_select <= next_request_gap_select;
            error_irq_enable <= next_error_irq_enable;
            chain_done_irq_enable <= next_chain_done_irq_enable;
            transfer_done_irq_enable <= next_transfer_done_irq_enable;
            transfer_running <= next_transfer_running;
            pci_to_ibus <= next_pci_to_ibus;
            irq_status <= next_irq_status;
            reg_rdata <= next_reg_rdata;
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs toward the agents and the interrupt line
    assign ibus_req = (state == dma_pkg::IBUS);
    assign ibus_write = pci_to_ibus;
    assign pci_access_valid = (state == dma_pkg::PCI);
    assign pci_access_write = !pci_to_ibus; // see R02
    assign pci_access_addr = {pci_side_transfer_address, 2'b00}; // see R01
    assign irq_enable_vec = {transfer_done_irq_enable,
                             chain_done_irq_enable,
                             error_irq_enable};
    assign irq = |(irq_status & irq_enable_vec); // see R13 R14 R16 R17

    ////////////////////////////////////////////////////////////////////////
    // checks; gap_seen counts clocks since the last internal-bus request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap_seen <= dma_pkg::SEEN_SAT;
        end else if (ibus_issue) begin
            gap_seen <= 12'h001;
        end else if (gap_seen != dma_pkg::SEEN_SAT) begin
            gap_seen <= gap_seen + 12'h001;
        end
    end

    a_gap_spacing_held: assert property ( // see R12
        @(posedge sys_clk) disable iff (rst)
        (ibus_issue && request_gap_select != dma_pkg::GAP_NONE)
        |-> (gap_seen >= {1'b0, dma_pkg::gap_cycles(request_gap_select)}))
        else $error("internal-bus request issued inside the gap");

    a_zero_count_idle: assert property ( // see R06
        @(posedge sys_clk) disable iff (rst)
        (state == dma_pkg::IDLE && transfer_running && !reg_wr && !chain_start
         && transfer_byte_count == dma_pkg::CNT_ZERO)
        |=> (state == dma_pkg::IDLE && !transfer_running))
        else $error("zero count did not end the transfer at once");

    a_run_stop_error: assert property ( // see R15
        @(posedge sys_clk) disable iff (rst)
        (ev_err && !reg_wr && !chain_start) |=> !transfer_running)
        else $error("running bit survived an error");

    a_count_word_step: assert property ( // see R07
        @(posedge sys_clk) disable iff (rst)
        (word_step && !reg_wr)
        |=> (transfer_byte_count == $past(transfer_byte_count) - 22'h1))
        else $error("count did not drop by one word");

    a_addr_word_step: assert property ( // see R01
        @(posedge sys_clk) disable iff (rst)
        (word_step && !reg_wr)
        |=> (pci_access_addr == $past(pci_access_addr) + 40'h4))
        else $error("pci address did not advance by one word");

    // set by a write, then held until software writes the register again
    a_fifo_clear_held: assert property ( // see R08
        @(posedge sys_clk) disable iff (rst)
        ((reg_wr && reg_addr == dma_pkg::OFS_CONFIG
          && reg_wdata[dma_pkg::CFG_FIFO_CLR])
         || (fifo_pointer_clear
             && !(reg_wr && reg_addr == dma_pkg::OFS_CONFIG)))
        |=> fifo_pointer_clear)
        else $error("fifo clear did not hold after being set");

    a_err_irq_gate: assert property ( // see R13
        @(posedge sys_clk) disable iff (rst)
        (ev_err && error_irq_enable && !reg_wr) |=> irq)
        else $error("enabled error raised no interrupt");

    a_chain_irq_gate: assert property ( // see R14
        @(posedge sys_clk) disable iff (rst)
        (irq_status == 3'h2 && !chain_done_irq_enable) |-> !irq)
        else $error("disabled chain event raised the interrupt");

    a_done_irq_gate: assert property ( // see R16
        @(posedge sys_clk) disable iff (rst)
        (ev_xfer_done && transfer_done_irq_enable && !reg_wr) |=> irq)
        else $error("enabled transfer done raised no interrupt");

    a_status_sticky: assert property ( // see R17
        @(posedge sys_clk) disable iff (rst)
        (irq_status[dma_pkg::IRQ_ERR] && !reg_wr)
        |=> irq_status[dma_pkg::IRQ_ERR])
        else $error("error status dropped without a clear");

    a_rdata_only_after: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(reg_rd) |-> (reg_rdata == 64'h0000_0000_0000_0000))
        else $error("read data outside the cycle after a read");

endmodule : bus_to_bus_dma_unit

// ===== verification/far_side_model.sv
// prompt agents for the internal bus and the pci side of the dma unit
// assumes pci_clk runs free, as a pci clock does, unrelated to sys_clk
`timescale 1ns/10ps
module far_side_model (
    // clocks
    input wire logic sys_clk,
    input wire logic pci_clk,
    // internal bus
    input wire logic ibus_req,
    output logic ibus_ack,
    // pci side
    input wire logic pci_access_valid,
    output logic pci_word_done
);
    ////////////////////////////////////////////////////////////////////////
    // ack one cycle into each request; never twice for one request
    initial ibus_ack = 1'h0;
    always @(posedge sys_clk) begin
        ibus_ack <= ibus_req && !ibus_ack;
    end
    // done launched after a pci rise and held one full pci period
    initial pci_word_done = 1'h0;
    always @(posedge pci_clk) begin
        pci_word_done <= pci_access_valid && !pci_word_done;
    end
endmodule : far_side_model

// ===== verification/tb.sv
// self-checking bench of the bus-to-bus dma unit
// assumes far_side_model answers both buses without stalling
`timescale 1ns/10ps
module tb;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic pci_clk = 1'h0;
    logic [15:0] reg_addr = 16'h0;
    logic [63:0] reg_wdata = 64'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [63:0] reg_rdata;
    logic [63:0] d;
    logic ibus_req, ibus_ack, valid, done, irq, fifo_clr, order;
    logic iwr, pwr;
    logic [39:0] paddr;
    logic ierr = 1'h0;
    int mismatches = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////
    // clocks: pci at 400 ns with an odd phase offset
    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #200 pci_clk = ~pci_clk;
    end
    // chain inputs and the pci error tied low; ibus error from the bench
    bus_to_bus_dma_unit u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ibus_req(ibus_req), .ibus_write(iwr),
        .ibus_ack(ibus_ack), .ibus_error(ierr),
        .internal_bus_byte_order(order), .fifo_pointer_clear(fifo_clr),
        .chain_enable(1'h0), .chain_start(1'h0), .pci_clk(pci_clk),
        .pci_word_done(done), .pci_error(1'h0),
        .pci_access_valid(valid), .pci_access_write(pwr),
        .pci_access_addr(paddr), .irq(irq));
    far_side_model u_far (
        .sys_clk(sys_clk), .pci_clk(pci_clk), .ibus_req(ibus_req),
        .ibus_ack(ibus_ack), .pci_access_valid(valid),
        .pci_word_done(done));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] a, input logic [63:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask : wr
    // read data is sampled once the taking edge has landed
    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // two-word transfer, polled with a bounded count until it ends
    task automatic run(input logic [63:0] ctl);
        wr(16'hD210, 64'h12_3456_7800);
        wr(16'hD218, 64'h8);
        wr(16'hD228, ctl);
        rd(16'hD228);
        for (int i = 0; i < 300 && d[6] !== 1'h0; i++)
            rd(16'hD228);
        chk("running", 64'h0, d & 64'h40);
        rd(16'hD218);
        chk("count", 64'h0, d);
        rd(16'hD210);
        chk("address", 64'h12_3456_7808, d);
        chk("pci_addr", 64'h12_3456_7808, paddr);
        chk("pci_write", !ctl[0], pwr);
        chk("ibus_write", ctl[0], iwr);
        // a plain transfer end counts as chain done too
        rd(16'hD230);
        chk("status", 64'h6, d);
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the expected run
    initial begin
        #2000000;
        mismatches++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        rd(16'hD220);
        chk("config", 64'h0, d);
        rd(16'hD300);
        chk("unmapped", 64'h0, d);
        wr(16'hD210, '1);
        wr(16'hD218, '1);
        @(posedge sys_clk);
        rst <= 1'h1;
        @(posedge sys_clk);
        rst <= 1'h0;
        rd(16'hD210);
        chk("addr_kept", 64'hFF_FFFF_FFFC, d);
        rd(16'hD218);
        chk("count_kept", 64'hFF_FFFC, d);
        wr(16'hD220, 64'h30_0000);
        rd(16'hD220);
        chk("cfg_rb", 64'h30_0000, d);
        chk("fifo_clear", 64'h1, fifo_clr);
        chk("byte_order", 64'h1, order);
        wr(16'hD220, 64'h800);
        run(64'h140);
        chk("irq_on", 64'h1, irq);
        wr(16'hD238, 64'h6);
        rd(16'hD230);
        chk("cleared", 64'h0, d);
        chk("irq_off", 64'h0, irq);
        wr(16'hD220, 64'h0);
        run(64'h41);
        chk("irq_masked", 64'h0, irq);
        wr(16'hD238, 64'h4);
        wr(16'hD218, 64'h0);
        wr(16'hD228, 64'h40);
        rd(16'hD228);
        chk("zero_run", 64'h0, d & 64'h40);
        chk("zero_req", 64'h0, ibus_req);
        // internal-bus error: the word is dropped and the run ends
        wr(16'hD238, 64'h7);
        wr(16'hD240, 64'h1);
        rd(16'hD220);
        chk("err_ie_alias", 64'h400, d);
        wr(16'hD218, 64'h4);
        wr(16'hD228, 64'h40);
        @(posedge sys_clk iff ibus_req);
        ierr <= 1'h1;
        @(posedge sys_clk);
        ierr <= 1'h0;
        rd(16'hD230);
        chk("err_status", 64'h1, d);
        chk("err_irq", 64'h1, irq);
        rd(16'hD228);
        chk("err_stop", 64'h0, d & 64'h40);
        rd(16'hD218);
        chk("err_count", 64'h4, d);
        finish_test;
    end
endmodule : tb
